/* File: core/ddc_top.sv */
/*
 * digital front end of a dual 8-bit converter: sample ports, control word
 * capture, power and interpolation decode, clock pin direction, pll lock flag
 * and an APB register view.
 * assumes every pin input is synchronous to pclk; the conversion clock is
 * seen as a level on clk_pin_in or diff_clk_in and its edges are detected.
 */
// Operation
// - bit 7 high forces power-down
// - bit 6 picks standby or run
// - bit 5 high selects 4x interpolation
// - bit 4 selects 2x or none
// - bits 3..0 trim channel A gain
// - control word taken on strobe fall
// - interleave takes both channels from port A
// - A on rising, B on falling edge
// - samples are 8-bit unsigned, bit 7 MSB
// - clock pin input with pll, else output
// - pll runs only with pll_on_select high
// - lock flag high only while locked
// - 8-bit word over port A, async strobe
// - reset: no interpolation, 0 dB, running
// - gain spans +0.4 to -0.35 dB
`timescale 1ns/1ps

module ddc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port_a_bits,
    input  wire logic [7:0]  port_b_bits,
    input  wire logic        config_write_strobe_n,
    input  wire logic        interleave_select,
    input  wire logic        pll_on_select,
    input  wire logic        diff_clk_in,
    input  wire logic        clk_pin_in,
    output logic             clk_pin_out,
    output logic             clk_pin_oe,
    output logic             pll_settled_flag,
    output logic      [7:0]  ch_a_sample,
    output logic      [7:0]  ch_b_sample,
    output logic      [2:0]  power_state,
    output logic      [2:0]  interp_mode,
    output logic      [3:0]  gain_trim_bits,
    output logic      [7:0]  gain_cdb
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]  ctrl_word_ff;
    logic [7:0]  pend_word_ff;
    logic        pend_ff;
    logic        strobe_prev_ff;
    logic        src_prev_ff;
    logic        il_phase_ff;
    logic [4:0]  lock_cnt_ff;
    logic        locked_ff;
    logic [7:0]  ch_a_ff;
    logic [7:0]  ch_b_ff;
    logic [2:0]  pwr_ff;
    logic [2:0]  interp_ff;
    logic [7:0]  gain_cdb_ff;
    logic        clk_out_ff;
    logic        clk_oe_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    // ************************************************************
    // edge detection and capture events
    // ************************************************************
    wire logic       src_clk    = pll_on_select ? clk_pin_in : diff_clk_in;
    wire logic       src_rise   = src_clk & ~src_prev_ff;
    wire logic       src_fall   = ~src_clk & src_prev_ff;
    wire logic       cw_fall    = strobe_prev_ff & ~config_write_strobe_n;
    wire logic       running    = (pwr_ff == ddc_pkg::DDC_PWR_RUN);

    // ************************************************************
    // apb decode
    // ************************************************************
    wire logic       apb_setup  = psel & ~penable;
    wire logic       apb_done   = psel & penable & pready_ff;
    wire logic       sel_ctrl   = (paddr == ddc_pkg::OFS_CTRL);
    wire logic       sel_status = (paddr == ddc_pkg::OFS_STATUS);
    wire logic       sel_samp   = (paddr == ddc_pkg::OFS_SAMPLES);
    wire logic       sel_gain   = (paddr == ddc_pkg::OFS_GAIN);
    wire logic       mapped     = sel_ctrl | sel_status | sel_samp | sel_gain;
    wire logic       apb_wr_ctl = apb_done & pwrite & sel_ctrl;

    // ************************************************************
    // pending word: strobe has priority over a software write
    // ************************************************************
    wire logic       load_pend  = cw_fall | apb_wr_ctl;
    wire logic [7:0] load_word  = cw_fall ? port_a_bits : pwdata[7:0];
    // applying only on a sample edge keeps a setting from changing mid-sample;
    // with the conversion clock stopped the word waits in the pending slot
    wire logic       apply      = pend_ff & src_rise;
    wire logic [7:0] nxt_ctrl_word = apply ? pend_word_ff : ctrl_word_ff;
    // set wins over clear: a word caught while another is applied stays pending
    wire logic       nxt_pend   = load_pend | (pend_ff & ~apply);
    wire logic [7:0] nxt_pend_word = load_pend ? load_word : pend_word_ff;

    // ************************************************************
    // control word decode
    // ************************************************************
    logic [2:0] nxt_pwr;
    logic [2:0] nxt_interp;

    always_comb begin
        case ({nxt_ctrl_word[ddc_pkg::CW_PD_BIT], nxt_ctrl_word[ddc_pkg::CW_RUN_BIT]})
            2'b10, 2'b11: nxt_pwr = ddc_pkg::DDC_PWR_DOWN;
            2'b01:        nxt_pwr = ddc_pkg::DDC_PWR_RUN;
            2'b00:        nxt_pwr = ddc_pkg::DDC_PWR_STANDBY;
            default:      nxt_pwr = ddc_pkg::DDC_PWR_DOWN;
        endcase
    end

    // a word with bit 5 set and bit 4 clear is still read as 4x here
    always_comb begin
        case ({nxt_ctrl_word[ddc_pkg::CW_F2_BIT], nxt_ctrl_word[ddc_pkg::CW_F1_BIT]})
            2'b10, 2'b11: nxt_interp = ddc_pkg::DDC_INTERP_4X;
            2'b01:        nxt_interp = ddc_pkg::DDC_INTERP_2X;
            2'b00:        nxt_interp = ddc_pkg::DDC_INTERP_1X;
            default:      nxt_interp = ddc_pkg::DDC_INTERP_1X;
        endcase
    end

    wire logic [3:0] nxt_gain_code = nxt_ctrl_word[ddc_pkg::CW_GAIN_MSB:ddc_pkg::CW_GAIN_LSB];
    // five hundredths of a dB per code step, code 0 at the top of the range
    wire logic [7:0] nxt_gain_cdb  = ddc_pkg::GAIN_TOP_CDB - {2'b00, nxt_gain_code, 2'b00}
                                     - {4'h0, nxt_gain_code};

    // ************************************************************
    // sample capture
    // ************************************************************
    // standby and power-down freeze the last samples
    wire logic       cap_a      = running & src_rise;
    wire logic       cap_b      = running & src_fall & (~interleave_select | il_phase_ff);
    wire logic [7:0] b_source   = interleave_select ? port_a_bits : port_b_bits;
    wire logic [7:0] nxt_ch_a   = cap_a ? port_a_bits : ch_a_ff;
    wire logic [7:0] nxt_ch_b   = cap_b ? b_source : ch_b_ff;
    wire logic       nxt_il_phase = cap_a ? 1'b1 : (cap_b ? 1'b0 : il_phase_ff);

    // ************************************************************
    // pll lock model
    // ************************************************************
    // counting stops at the lock count, so the flag cannot wrap back low
    wire logic       lock_done  = (lock_cnt_ff == ddc_pkg::LOCK_EDGES);
    wire logic [4:0] nxt_lock_cnt = ~pll_on_select ? 5'h00 :
                                    (src_rise & ~lock_done) ? lock_cnt_ff + 5'h01 : lock_cnt_ff;
    wire logic       nxt_locked = pll_on_select & (nxt_lock_cnt == ddc_pkg::LOCK_EDGES);

    // ************************************************************
    // apb read mux
    // ************************************************************
    wire logic [31:0] rd_ctrl   = {23'h000000, pend_ff, ctrl_word_ff};
    wire logic [31:0] rd_status = {23'h000000, pll_on_select, interleave_select, locked_ff,
                                   interp_ff, pwr_ff};
    wire logic [31:0] rd_samp   = {16'h0000, ch_b_ff, ch_a_ff};
    wire logic [31:0] rd_gain   = {24'h000000, gain_cdb_ff};
    wire logic [31:0] rd_mux    = sel_ctrl   ? rd_ctrl   :
                                  sel_status ? rd_status :
                                  sel_samp   ? rd_samp   :
                                  sel_gain   ? rd_gain   : 32'h00000000;
    wire logic        nxt_pready = apb_setup & ~pready_ff;
    wire logic [31:0] nxt_prdata = (apb_setup & ~pwrite) ? rd_mux : prdata_ff;
    wire logic        nxt_pslverr = apb_setup & ~mapped;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_word_ff   <= ddc_pkg::CW_RESET;
            pend_word_ff   <= ddc_pkg::CW_RESET;
            pend_ff        <= 1'b0;
            strobe_prev_ff <= 1'b1;
            src_prev_ff    <= 1'b0;
            il_phase_ff    <= 1'b0;
        end else begin
            ctrl_word_ff   <= nxt_ctrl_word;
            pend_word_ff   <= nxt_pend_word;
            pend_ff        <= nxt_pend;
            strobe_prev_ff <= config_write_strobe_n;
            src_prev_ff    <= src_clk;
            il_phase_ff    <= nxt_il_phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_ff      <= ddc_pkg::DDC_PWR_RUN;
            interp_ff   <= ddc_pkg::DDC_INTERP_1X;
            gain_cdb_ff <= 8'h00;
            ch_a_ff     <= 8'h00;
            ch_b_ff     <= 8'h00;
        end else begin
            pwr_ff      <= nxt_pwr;
            interp_ff   <= nxt_interp;
            gain_cdb_ff <= nxt_gain_cdb;
            ch_a_ff     <= nxt_ch_a;
            ch_b_ff     <= nxt_ch_b;
        end
    end

    // the clock pin is driven only while the pll is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_ff  <= 1'b0;
            clk_oe_ff   <= 1'b0;
            lock_cnt_ff <= 5'h00;
            locked_ff   <= 1'b0;
        end else begin
            clk_out_ff  <= diff_clk_in;
            clk_oe_ff   <= ~pll_on_select;
            lock_cnt_ff <= nxt_lock_cnt;
            locked_ff   <= nxt_locked;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign clk_pin_out      = clk_out_ff;
    assign clk_pin_oe       = clk_oe_ff;
    assign pll_settled_flag = locked_ff;
    assign ch_a_sample      = ch_a_ff;
    assign ch_b_sample      = ch_b_ff;
    assign power_state      = pwr_ff;
    assign interp_mode      = interp_ff;
    assign gain_trim_bits   = ctrl_word_ff[3:0];
    assign gain_cdb         = gain_cdb_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_pd;
        @(posedge pclk) disable iff (!presetn)
        ctrl_word_ff[7] |-> (pwr_ff == ddc_pkg::DDC_PWR_DOWN);
    endproperty
    a_pd: assert property (p_pd) else $error("power-down bit not obeyed");

    property p_run;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_word_ff[7] |-> (pwr_ff == (ctrl_word_ff[6] ? ddc_pkg::DDC_PWR_RUN : ddc_pkg::DDC_PWR_STANDBY));
    endproperty
    a_run: assert property (p_run) else $error("run bit decode wrong");

    property p_f2;
        @(posedge pclk) disable iff (!presetn)
        ctrl_word_ff[5] |-> (interp_ff == ddc_pkg::DDC_INTERP_4X);
    endproperty
    a_f2: assert property (p_f2) else $error("4x not selected");

    property p_f1;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_word_ff[5] |-> (interp_ff == (ctrl_word_ff[4] ? ddc_pkg::DDC_INTERP_2X : ddc_pkg::DDC_INTERP_1X));
    endproperty
    a_f1: assert property (p_f1) else $error("2x or 1x decode wrong");

    property p_gain;
        @(posedge pclk) disable iff (!presetn)
        apply |=> (gain_trim_bits == $past(pend_word_ff[3:0]))
                  && (gain_cdb == 8'h28 - 8'h05 * {4'h0, $past(pend_word_ff[3:0])});
    endproperty
    a_gain: assert property (p_gain) else $error("gain trim not applied");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (strobe_prev_ff && !config_write_strobe_n) |=> pend_ff && (pend_word_ff == $past(port_a_bits));
    endproperty
    a_capture: assert property (p_capture) else $error("control word not captured");

    property p_il_b;
        @(posedge pclk) disable iff (!presetn)
        (cap_b && interleave_select) |=> (ch_b_sample == $past(port_a_bits));
    endproperty
    a_il_b: assert property (p_il_b) else $error("interleave B not from port A");

    property p_edges;
        @(posedge pclk) disable iff (!presetn)
        (running && src_fall && !interleave_select) |=> (ch_b_sample == $past(port_b_bits))
                                                       && $stable(ch_a_sample);
    endproperty
    a_edges: assert property (p_edges) else $error("channel B edge capture wrong");

    property p_clkdir;
        @(posedge pclk) disable iff (!presetn)
        pll_on_select [*2] |-> !clk_pin_oe;
    endproperty
    a_clkdir: assert property (p_clkdir) else $error("clock pin driven with pll on");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        !pll_on_select |=> !pll_settled_flag;
    endproperty
    a_lock: assert property (p_lock) else $error("lock flag high with pll off");

    property p_apply;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_word_ff != $past(ctrl_word_ff)) |-> $past(src_rise) && $past(pend_ff);
    endproperty
    a_apply: assert property (p_apply) else $error("word applied off a sample edge");

    property p_apb;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer timing wrong");

    c_cw_write:  cover property (@(posedge pclk) disable iff (!presetn) cw_fall ##[1:40] apply);
    c_pd_mode:   cover property (@(posedge pclk) disable iff (!presetn) pwr_ff == ddc_pkg::DDC_PWR_DOWN);
    c_four_x:    cover property (@(posedge pclk) disable iff (!presetn) interp_ff == ddc_pkg::DDC_INTERP_4X);
    c_interleave:cover property (@(posedge pclk) disable iff (!presetn) interleave_select && cap_a ##[1:20] cap_b);
    c_locked:    cover property (@(posedge pclk) disable iff (!presetn) $rose(pll_settled_flag));

endmodule : ddc_top

/* File: core/ddc_pkg.sv */
/*
 * constants, field layout, register map and enumerations for the dual
 * converter input and control port.
 * assumes a single 200 MHz pclk domain and software access over APB.
 */
package ddc_pkg;

    // ************************************************************
    // control word layout
    // ************************************************************
    localparam int unsigned CW_WIDTH       = 8;
    localparam int unsigned CW_PD_BIT      = 7;
    localparam int unsigned CW_RUN_BIT     = 6;
    localparam int unsigned CW_F2_BIT      = 5;
    localparam int unsigned CW_F1_BIT      = 4;
    localparam int unsigned CW_GAIN_MSB    = 3;
    localparam int unsigned CW_GAIN_LSB    = 0;
    localparam int unsigned SAMPLE_WIDTH   = 8;

    // running, no interpolation, gain code 8 which is the 0 dB step
    localparam logic [7:0]  CW_RESET       = 8'h48;

    // gain in hundredths of a dB: top of the range
    localparam logic [7:0]  GAIN_TOP_CDB   = 8'h28;

    // ************************************************************
    // pll lock model
    // ************************************************************
    localparam int unsigned LOCK_CNT_W     = 5;
    localparam logic [4:0]  LOCK_EDGES     = 5'h10;

    // ************************************************************
    // apb register map
    // ************************************************************
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_SAMPLES    = 8'h08;
    localparam logic [7:0]  OFS_GAIN       = 8'h0C;
    localparam int unsigned CTRL_PEND_BIT  = 8;
    localparam int unsigned ST_PWR_LSB     = 0;
    localparam int unsigned ST_INTERP_LSB  = 3;
    localparam int unsigned ST_LOCK_BIT    = 6;
    localparam int unsigned ST_IL_BIT      = 7;
    localparam int unsigned ST_PLLON_BIT   = 8;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [2:0] {
        DDC_PWR_DOWN    = 3'b001,
        DDC_PWR_STANDBY = 3'b010,
        DDC_PWR_RUN     = 3'b100
    } ddc_pwr_e;

    typedef enum logic [2:0] {
        DDC_INTERP_1X = 3'b001,
        DDC_INTERP_2X = 3'b010,
        DDC_INTERP_4X = 3'b100
    } ddc_interp_e;

endpackage : ddc_pkg

/* File: verif/ddc_host.sv */
/*
 * host model: drives the sample ports, the control strobe and the sample clocks.
 * assumes a pclk-synchronous bench; every pin changes just after a rising pclk edge.
 */
`timescale 1ns/1ps

module ddc_host (
    input  wire logic       pclk,
    output logic      [7:0] port_a_bits,
    output logic      [7:0] port_b_bits,
    output logic            config_write_strobe_n,
    output logic            diff_clk_in,
    output logic            clk_pin_in
);
    // ************************************************************
    // idle levels
    // ************************************************************
    initial begin
        port_a_bits           = 8'h00;
        port_b_bits           = 8'h00;
        config_write_strobe_n = 1'b1;
        diff_clk_in           = 1'b0;
        clk_pin_in            = 1'b0;
    end

    // ************************************************************
    // host tasks
    // ************************************************************
    task automatic send_cw(input logic [7:0] w);
        logic [7:0] v;
        v = w;
        if (v[5]) v[4] = 1'b1;
        @(posedge pclk) port_a_bits <= v;
        @(posedge pclk) config_write_strobe_n <= 1'b0;
        repeat (2) @(posedge pclk);
        config_write_strobe_n <= 1'b1;
        // released port shows the inverse so a late capture cannot pass
        @(posedge pclk) port_a_bits <= ~v;
    endtask : send_cw

    task automatic set_data(input logic [7:0] a, input logic [7:0] b);
        @(posedge pclk);
        port_a_bits <= a;
        port_b_bits <= b;
    endtask : set_data

    // clock stands still between calls; two more edges let the detect land
    task automatic clk_to(input logic lvl, input logic on_pin);
        @(posedge pclk);
        if (on_pin) clk_pin_in <= lvl;
        else diff_clk_in <= lvl;
        repeat (2) @(posedge pclk);
    endtask : clk_to
endmodule : ddc_host

/* File: verif/ddc_top_tb.sv */
/*
 * self-checking bench: apb tasks, control words, sample capture, clock pin and lock.
 * assumes the host model drives the pins and the bench drives apb and mode levels.
 */
`timescale 1ns/1ps

module ddc_top_tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, il = 1'b0, pll_on = 1'b0;
    logic [7:0]  pa, pb, ch_a, ch_b, gcdb, w;
    logic        strobe_n, dclk, pin_in, pin_out, pin_oe, lock;
    logic [2:0]  pwr, interp, pwr_prev;
    logic [3:0]  gtrim;
    int          fail_count = 0, num_checks = 0;
    logic [7:0]  words [5] = '{8'h00, 8'h50, 8'h73, 8'hCF, 8'h48};

    always #2.5 pclk = ~pclk;

    ddc_host host_u (.pclk(pclk), .port_a_bits(pa), .port_b_bits(pb), .config_write_strobe_n(strobe_n),
                     .diff_clk_in(dclk), .clk_pin_in(pin_in));

    ddc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                   .port_a_bits(pa), .port_b_bits(pb), .config_write_strobe_n(strobe_n),
                   .interleave_select(il), .pll_on_select(pll_on), .diff_clk_in(dclk),
                   .clk_pin_in(pin_in), .clk_pin_out(pin_out), .clk_pin_oe(pin_oe),
                   .pll_settled_flag(lock), .ch_a_sample(ch_a), .ch_b_sample(ch_b),
                   .power_state(pwr), .interp_mode(interp), .gain_trim_bits(gtrim), .gain_cdb(gcdb));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_val({31'h0, got}, {31'h0, exp}, msg);
    endtask : chk_bit

    // master holds every signal until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    initial begin
        #200000;
        fail_count++;
        summarize();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk_val(pwr, ddc_pkg::DDC_PWR_RUN, "reset power");
        chk_val(interp, ddc_pkg::DDC_INTERP_1X, "reset interp");
        chk_val(gcdb, 8'h00, "reset gain");
        apb(ddc_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk_val(rd[7:0], 8'h48, "reset word");
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            w        = words[i];
            pwr_prev = pwr;
            host_u.send_cw(w);
            apb(ddc_pkg::OFS_CTRL, 1'b0, 32'h0);
            chk_bit(rd[8], 1'b1, "word pending");
            chk_val(pwr, pwr_prev, "held until sample edge");
            host_u.clk_to(1'b1, 1'b0);
            chk_val(pwr, w[7] ? 3'b001 : (w[6] ? 3'b100 : 3'b010), "power");
            chk_val(interp, w[5] ? 3'b100 : (w[4] ? 3'b010 : 3'b001), "interp");
            chk_val(gtrim, w[3:0], "gain code");
            chk_val(gcdb, 8'(8'h28 - 8'h05 * {4'h0, w[3:0]}), "gain db");
            host_u.clk_to(1'b0, 1'b0);
        end
        $display("test control word done");
        host_u.set_data(8'hA5, 8'h3C);
        host_u.clk_to(1'b1, 1'b0);
        chk_val(ch_a, 8'hA5, "sample a rise");
        host_u.set_data(8'h11, 8'h3C);
        host_u.clk_to(1'b0, 1'b0);
        chk_val(ch_b, 8'h3C, "sample b fall");
        il <= 1'b1;
        host_u.set_data(8'h81, 8'hC3);
        host_u.clk_to(1'b1, 1'b0);
        chk_val(ch_a, 8'h81, "interleave a");
        host_u.set_data(8'h7E, 8'hC3);
        host_u.clk_to(1'b0, 1'b0);
        chk_val(ch_b, 8'h7E, "interleave b from port a");
        apb(ddc_pkg::OFS_SAMPLES, 1'b0, 32'h0);
        chk_val(rd[15:0], 16'h7E81, "samples register");
        il <= 1'b0;
        $display("test samples done");
        chk_bit(pin_oe, 1'b1, "pin driven without pll");
        host_u.clk_to(1'b1, 1'b0);
        chk_bit(pin_out, 1'b1, "pin follows diff clock");
        host_u.clk_to(1'b0, 1'b0);
        pll_on <= 1'b1;
        repeat (2) @(posedge pclk);
        chk_bit(pin_oe, 1'b0, "pin is input with pll");
        chk_bit(lock, 1'b0, "not locked yet");
        for (int i = 0; i < 16; i++) begin
            host_u.clk_to(1'b1, 1'b1);
            host_u.clk_to(1'b0, 1'b1);
        end
        chk_bit(lock, 1'b1, "locked after rises");
        apb(ddc_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk_val(rd[8:0], 9'h14C, "status");
        pll_on <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_bit(lock, 1'b0, "lock drops with pll off");
        apb(8'h10, 1'b0, 32'h0);
        chk_bit(err, 1'b1, "unmapped address");
        apb(ddc_pkg::OFS_CTRL, 1'b1, 32'h0000003A);
        apb(ddc_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk_val(rd[8:0], 9'h148, "software word pending");
        host_u.clk_to(1'b1, 1'b0);
        chk_val(pwr, ddc_pkg::DDC_PWR_STANDBY, "software word power");
        chk_val(interp, ddc_pkg::DDC_INTERP_4X, "software word interp");
        chk_val(gtrim, 4'hA, "software word gain");
        $display("test pll and apb done");
        summarize();
    end
endmodule : ddc_top_tb
